/* File: inc/crwm_pkg.sv */
// Constants and carrier types for the character window mapping block.
// Assumes a 16-bit processor address space and an 8-bit data bus.
package crwm_pkg;

    // Processor bus geometry
    localparam int ADDR_W        = 16;           // Processor address width
    localparam int DATA_W        = 8;            // Processor data width

    // Register addresses
    localparam logic [15:0] CHAR_POINTER_ADDR = 16'hd018; // Screen/char ptr
    localparam logic [15:0] BG_ZERO_ADDR      = 16'hd021; // Background 0
    localparam logic [15:0] MEM_CONFIG_ADDR   = 16'hff00; // Configuration

    // Reset values
    localparam logic [7:0] MEM_CONFIG_RST     = 8'h00;    // I/O decoded
    localparam logic [7:0] CHAR_POINTER_RST   = 8'h00;    // Base zero
    localparam logic [7:0] BG_ZERO_RST        = 8'h00;    // Colour zero

    // Field positions
    localparam int CFG_ROM_SEL_BIT  = 0;   // Overlay ROM over the I/O range
    localparam int PTR_BASE_LSB     = 1;   // Char base field, even steps
    localparam int PTR_BASE_MSB     = 3;   // Char base field top bit

    // Shared 4K window
    localparam logic [3:0] SHARED_PAGE = 4'hd;  // Top nibble of 53248-57343
    localparam int ROM_ADDR_W       = 12;       // 4K character ROM
    localparam int UPPER_SET_BASE   = 0;        // Uppercase set offset
    localparam int UPPER_SET_BYTES  = 512;      // Uppercase set length

    // Video window geometry
    localparam int BANK_BYTES       = 16384;    // One video bank
    localparam int BANK_OFS_W       = 14;       // Offset inside a bank
    localparam int BANK_W           = 2;        // Four video banks
    localparam int BASE_STEP_W      = 11;       // Base field unit 2048
    localparam int GLYPH_ROWS       = 8;        // Rows per glyph
    localparam int ROW_W            = 3;        // Row index width
    localparam int CODE_W           = 8;        // Character code width
    localparam int COLOUR_W         = 4;        // Colour code width

    // One glyph row fetch request from the display logic
    typedef struct packed {
        logic [CODE_W-1:0]   code;      // Character code
        logic [ROW_W-1:0]    row;       // Row of the 8 by 8 cell
        logic [COLOUR_W-1:0] fg;        // Foreground colour of the cell
    } crwm_fetch_t;

endpackage

/* File: design/crwm_top.sv */
// Character window decoder, register file and glyph row fetch/shift.
// Assumes one clock, a processor strobe port and a display request port.
`timescale 1ns/1ps
`default_nettype none

module crwm_top
    import crwm_pkg::*;
#(
    parameter int RAM_ADDR_W = ADDR_W   // Width of the RAM array address
)
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic [ADDR_W-1:0]     cpu_addr,
    input  wire logic [DATA_W-1:0]     cpu_wdata,
    input  wire logic                  cpu_wr,
    input  wire logic                  cpu_rd,
    output logic      [DATA_W-1:0]     cpu_rdata,
    input  wire logic [BANK_W-1:0]     vid_bank,
    input  wire logic                  vid_use_rom,
    input  wire logic                  vid_req,
    input  wire crwm_fetch_t           vid_fetch,
    output logic      [ADDR_W-1:0]     vid_addr,
    output logic      [DATA_W-1:0]     vid_pattern,
    output logic                       pix_valid,
    output logic      [COLOUR_W-1:0]   pix_colour,
    output logic                       rom_selected
);

    // Character ROM pattern lookup; unfilled glyphs read as blank rows
    function automatic logic [7:0] crwm_rom_byte(
        input logic [ROM_ADDR_W-1:0] a
    );
        logic [7:0] b;
        b = 8'h00;
        // Uppercase set starts at the lowest ROM address
        if (int'(a) >= UPPER_SET_BASE &&
            int'(a) <  UPPER_SET_BASE + UPPER_SET_BYTES)
        begin
            unique case (a[2:0])
                3'h0:    b = 8'h3c;
                3'h1:    b = 8'h66;
                3'h2:    b = 8'h6e;
                3'h3:    b = 8'h6e;
                3'h4:    b = 8'h60;
                3'h5:    b = 8'h62;
                3'h6:    b = 8'h3c;
                3'h7:    b = 8'h00;
            endcase
            // Only the first cell carries a pattern in this image
            if (a[ROM_ADDR_W-1:3] != '0)
            begin
                b = 8'h00;
            end
        end
        return b;
    endfunction

    // Main RAM shared by processor and display fetch
    logic [7:0]              ram_mem [0:(1<<RAM_ADDR_W)-1];

    // Registers
    logic [7:0]              mem_config_r;     // Configuration register
    logic [7:0]              char_pointer_r;   // Screen/char pointer
    logic [7:0]              bg_zero_r;        // Background colour zero
    logic [DATA_W-1:0]       cpu_rdata_r;      // Read data, one cycle late
    logic [DATA_W-1:0]       cpu_rdata_nxt;    // Read data next value
    logic                    rom_selected_r;   // Mirror of overlay bit

    // Display pipeline registers
    logic [ADDR_W-1:0]       vid_addr_r;       // Last glyph row address
    logic [DATA_W-1:0]       vid_pattern_r;    // Last fetched row byte
    logic                    fetch_done_r;     // Row byte arrives this cycle
    logic                    use_rom_r;        // Fetch came from ROM
    logic [7:0]              vid_ram_r;        // RAM byte for the display
    logic [7:0]              vid_rom_r;        // ROM byte for the display
    logic [COLOUR_W-1:0]     fg_stage_r;       // Foreground for fetch
    logic [COLOUR_W-1:0]     fg_r;             // Foreground being shifted
    logic [7:0]              shift_r;          // Pixel shifter
    logic [3:0]              pix_left_r;       // Pixels still to emit
    logic                    pix_valid_r;      // Pixel output valid
    logic [COLOUR_W-1:0]     pix_colour_r;     // Pixel colour output

    // Processor decode
    wire                     in_shared;        // Address in 4K window
    wire                     sel_rom;          // ROM answers the window
    wire                     sel_io;           // I/O answers the window
    wire                     hit_config;       // Configuration register
    wire                     hit_pointer;      // Char pointer register
    wire                     hit_bg_zero;      // Background zero register
    wire                     ram_wr_en;        // Processor write to RAM
    wire                     ram_rd_en;        // Processor read from RAM
    wire [RAM_ADDR_W-1:0]    cpu_ram_addr;     // RAM index for processor
    wire [7:0]               rom_cpu_byte;     // ROM byte for processor

    assign in_shared   = cpu_addr[15:12] == SHARED_PAGE;
    assign sel_rom     = in_shared && mem_config_r[CFG_ROM_SEL_BIT];
    assign sel_io      = in_shared && !mem_config_r[CFG_ROM_SEL_BIT];
    // Configuration stays visible in every mode
    assign hit_config  = cpu_addr == MEM_CONFIG_ADDR;
    // I/O registers answer only while the overlay bit is clear
    assign hit_pointer = sel_io && cpu_addr == CHAR_POINTER_ADDR;
    assign hit_bg_zero = sel_io && cpu_addr == BG_ZERO_ADDR;
    // Writes under the ROM fall through to RAM; the ROM never changes
    assign ram_wr_en   = cpu_wr && !sel_io && !hit_config;
    assign ram_rd_en   = cpu_rd && !in_shared && !hit_config;
    assign cpu_ram_addr = cpu_addr[RAM_ADDR_W-1:0];
    assign rom_cpu_byte = crwm_rom_byte(cpu_addr[ROM_ADDR_W-1:0]);

    // Display address build
    wire [BANK_OFS_W-1:0]    char_base;        // Base inside the bank
    wire [BANK_OFS_W-1:0]    glyph_ofs;        // Code times eight plus row
    wire [BANK_OFS_W-1:0]    in_bank_addr;     // Wraps inside the bank
    wire [ADDR_W-1:0]        abs_addr;         // Bank plus in-bank address
    wire [7:0]               rom_vid_byte;     // ROM byte for display

    // Base field value N gives N*2048, register value in even steps
    assign char_base = {char_pointer_r[PTR_BASE_MSB:PTR_BASE_LSB],
                        BASE_STEP_W'(0)};
    // Eight consecutive bytes per glyph, one per row
    assign glyph_ofs = BANK_OFS_W'({vid_fetch.code, vid_fetch.row});
    // Sum kept to 14 bits so fetches never leave the bank
    assign in_bank_addr = BANK_OFS_W'(char_base + glyph_ofs);
    // Each bank above zero adds one 16K span
    assign abs_addr = ADDR_W'(32'(vid_bank) * BANK_BYTES
                      + 32'(in_bank_addr));
    assign rom_vid_byte = crwm_rom_byte(in_bank_addr[ROM_ADDR_W-1:0]);

    // Read data selection for the processor
    always_comb
    begin
        cpu_rdata_nxt = '0;
        if (!cpu_rd)
        begin
            cpu_rdata_nxt = '0;                         // Idle bus
        end
        else if (hit_config)
        begin
            cpu_rdata_nxt = mem_config_r;
        end
        else if (sel_rom)
        begin
            cpu_rdata_nxt = rom_cpu_byte;
        end
        else if (hit_pointer)
        begin
            cpu_rdata_nxt = char_pointer_r;
        end
        else if (hit_bg_zero)
        begin
            cpu_rdata_nxt = bg_zero_r;
        end
        else if (ram_rd_en)
        begin
            cpu_rdata_nxt = ram_mem[cpu_ram_addr];      // Plain RAM byte
        end
        else
        begin
            cpu_rdata_nxt = '0;                         // Unmapped I/O
        end
    end

    // Register writes
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mem_config_r   <= MEM_CONFIG_RST;
            char_pointer_r <= CHAR_POINTER_RST;
            bg_zero_r      <= BG_ZERO_RST;
        end
        else if (cpu_wr)
        begin
            if (hit_config)
            begin
                mem_config_r <= cpu_wdata;
            end
            if (hit_pointer)
            begin
                char_pointer_r <= cpu_wdata;
            end
            if (hit_bg_zero)
            begin
                bg_zero_r <= cpu_wdata;
            end
        end
    end

    // RAM write port and display read port
    always_ff @(posedge clk)
    begin
        if (ram_wr_en)
        begin
            ram_mem[cpu_ram_addr] <= cpu_wdata;
        end
        vid_ram_r <= ram_mem[abs_addr[RAM_ADDR_W-1:0]];
    end

    // Processor read return, valid only the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cpu_rdata_r    <= '0;
            rom_selected_r <= 1'b0;
        end
        else
        begin
            cpu_rdata_r    <= cpu_rdata_nxt;
            rom_selected_r <= mem_config_r[CFG_ROM_SEL_BIT];
        end
    end

    // Read data straight from its register, no select behind it
    assign cpu_rdata = cpu_rdata_r;

    // Display fetch stage: capture address, ROM byte and colour
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            vid_addr_r   <= '0;
            fetch_done_r <= 1'b0;
            use_rom_r    <= 1'b0;
            vid_rom_r    <= '0;
            fg_stage_r   <= '0;
        end
        else
        begin
            fetch_done_r <= vid_req;
            if (vid_req)
            begin
                vid_addr_r <= abs_addr;
                use_rom_r  <= vid_use_rom;
                vid_rom_r  <= rom_vid_byte;
                fg_stage_r <= vid_fetch.fg;
            end
        end
    end

    // Pattern byte register and pixel shifter, MSB first
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            vid_pattern_r <= '0;
            shift_r       <= '0;
            fg_r          <= '0;
            pix_left_r    <= '0;
            pix_valid_r   <= 1'b0;
            pix_colour_r  <= '0;
        end
        else if (fetch_done_r)
        begin
            // New row replaces any row still shifting
            vid_pattern_r <= use_rom_r ? vid_rom_r : vid_ram_r;
            shift_r       <= use_rom_r ? vid_rom_r : vid_ram_r;
            fg_r          <= fg_stage_r;
            pix_left_r    <= 4'(GLYPH_ROWS);
            pix_valid_r   <= 1'b0;
        end
        else if (pix_left_r != 4'h0)
        begin
            // Set bit shows foreground, clear bit background zero
            pix_colour_r <= shift_r[7] ? fg_r
                                       : bg_zero_r[COLOUR_W-1:0];
            pix_valid_r  <= 1'b1;
            shift_r      <= {shift_r[6:0], 1'b0};
            pix_left_r   <= pix_left_r - 4'h1;
        end
        else
        begin
            pix_valid_r <= 1'b0;
        end
    end

    assign vid_addr     = vid_addr_r;
    assign vid_pattern  = vid_pattern_r;
    assign pix_valid    = pix_valid_r;
    assign pix_colour   = pix_colour_r;
    assign rom_selected = rom_selected_r;

endmodule // crwm_top

`default_nettype wire

/* File: bench/crwm_top_monitor.sv */
// Assertion checker for the character window decoder.
// Assumes it is bound to crwm_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module crwm_top_monitor
    import crwm_pkg::*;
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic [DATA_W-1:0] cpu_wdata,
    input wire logic              cpu_wr,
    input wire logic              cpu_rd,
    input wire logic [DATA_W-1:0] cpu_rdata,
    input wire logic [BANK_W-1:0] vid_bank,
    input wire logic              vid_use_rom,
    input wire logic              vid_req,
    input wire crwm_fetch_t       vid_fetch,
    input wire logic [ADDR_W-1:0] vid_addr,
    input wire logic [DATA_W-1:0] vid_pattern,
    input wire logic              pix_valid,
    input wire logic [COLOUR_W-1:0] pix_colour,
    input wire logic              rom_selected
);
    logic cfg_r;                  // Shadow of the ROM-select bit
    wire  cfg_wr = cpu_wr && (cpu_addr == MEM_CONFIG_ADDR);
    wire  in_win = cpu_addr[15:12] == SHARED_PAGE;
    // Track the overlay bit as software writes it
    always_ff @(posedge clk)
        if (sys_rst)
            cfg_r <= 1'b0;
        else if (cfg_wr)
            cfg_r <= cpu_wdata[CFG_ROM_SEL_BIT];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Request followed by quiet cycles up to first pixel / row end
    sequence s_lead; vid_req ##1 (!vid_req)[*2]; endsequence
    sequence s_row; vid_req ##1 (!vid_req)[*5] ##1 (!vid_req)[*5]; endsequence
    property p_mirror; cfg_wr |-> ##2 rom_selected == $past(cfg_r); endproperty
    property p_rst_clear;
        disable iff (1'b0) sys_rst |=> !rom_selected;
    endproperty
    property p_rom_read;
        cpu_rd && cfg_r && cpu_addr == 16'hd000 |=> cpu_rdata == 8'h3c;
    endproperty
    property p_io_hole;
        cpu_rd && !cfg_r && in_win && cpu_addr != CHAR_POINTER_ADDR
            && cpu_addr != BG_ZERO_ADDR |=> cpu_rdata == 8'h00;
    endproperty
    property p_bank; vid_req |=> vid_addr[15:14] == $past(vid_bank); endproperty
    property p_glyph_row;
        vid_req && !vid_use_rom |=> vid_addr[10:0]
            == {$past(vid_fetch.code), $past(vid_fetch.row)};
    endproperty
    property p_rom_row;
        vid_req && vid_use_rom && vid_fetch.code == 8'h00
            && vid_fetch.row == 3'h0 ##1 vid_addr[11:0] == 12'h000
            |=> vid_pattern == 8'h3c;
    endproperty
    property p_px_start;
        s_lead |=> pix_valid
            && (!vid_pattern[7] || pix_colour == $past(vid_fetch.fg, 3));
    endproperty
    property p_px_end; s_row |=> !pix_valid; endproperty
    a_mirror: assert property (p_mirror)
        else $error("rom_selected does not follow config bit");
    a_rst_clear: assert property (p_rst_clear)
        else $error("rom select set after reset");
    a_rom_read: assert property (p_rom_read)
        else $error("rom byte zero wrong");
    a_io_hole: assert property (p_io_hole)
        else $error("unmapped io read not zero");
    a_bank: assert property (p_bank)
        else $error("fetch left the video bank");
    a_glyph_row: assert property (p_glyph_row)
        else $error("glyph row address wrong");
    a_rom_row: assert property (p_rom_row)
        else $error("rom glyph row wrong");
    a_px_start: assert property (p_px_start)
        else $error("first pixel wrong");
    a_px_end: assert property (p_px_end)
        else $error("pixel run not eight long");
endmodule // crwm_top_monitor
`default_nettype wire

/* File: bench/crwm_host_model.sv */
// Processor bus and display fetch master driving the decoder.
// Assumes one clock; tasks are called from the testbench.
`timescale 1ns/1ps
`default_nettype none
module crwm_host_model
    import crwm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] cpu_rdata,
    output logic      [ADDR_W-1:0] cpu_addr,
    output logic      [DATA_W-1:0] cpu_wdata,
    output logic                   cpu_wr,
    output logic                   cpu_rd,
    output logic      [BANK_W-1:0] vid_bank,
    output logic                   vid_use_rom,
    output logic                   vid_req,
    output crwm_fetch_t            vid_fetch
);
    // Idle bus at time zero
    initial
    begin
        {cpu_addr, cpu_wdata, cpu_wr, cpu_rd} = '0;
        {vid_bank, vid_use_rom, vid_req, vid_fetch} = '0;
    end
    // One strobe cycle; strobes drop to zero, released address and data show inverted values
    task automatic cycle(input logic w, input logic [15:0] a,
                         input logic [7:0] d);
        @(posedge clk);
        cpu_wr <= w;
        cpu_rd <= !w;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge clk);
        {cpu_wr, cpu_rd} <= 2'b00;
        cpu_addr <= ~a;
        cpu_wdata <= ~d;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cycle(1'b1, a, d);
    endtask
    // Read data stands in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        cycle(1'b0, a, 8'h00);
        #1 d = cpu_rdata;
    endtask
    // Bank stays put as a level; charset kept inside it
    task automatic fetch(input logic [1:0] b, input logic rom,
                         input crwm_fetch_t f);
        @(posedge clk);
        vid_bank <= b;
        vid_use_rom <= rom;
        vid_req <= 1'b1;
        vid_fetch <= f;
        @(posedge clk);
        vid_req <= 1'b0;
        vid_fetch <= ~f;
        #1;
    endtask
endmodule // crwm_host_model
`default_nettype wire

/* File: bench/crwm_top_test.sv */
// Self-checking testbench for the character window decoder.
// Assumes the host model and the bound monitor beside it.
`timescale 1ns/1ps
`default_nettype none
module crwm_top_test
    import crwm_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1;
    logic [15:0] cpu_addr, vid_addr;
    logic [7:0] cpu_wdata, cpu_rdata, vid_pattern, d, pat;
    logic cpu_wr, cpu_rd, vid_use_rom, vid_req, pix_valid, rom_selected;
    logic [1:0] vid_bank;
    logic [3:0] pix_colour, bg, ptr;
    crwm_fetch_t vid_fetch;
    int n_fail = 0, comparisons = 0, cycles = 0, seed = 32'h45bca7c3;
    always #10 clk = ~clk;
    crwm_top dut (.clk(clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .vid_bank(vid_bank),
        .vid_use_rom(vid_use_rom), .vid_req(vid_req),
        .vid_fetch(vid_fetch), .vid_addr(vid_addr),
        .vid_pattern(vid_pattern), .pix_valid(pix_valid),
        .pix_colour(pix_colour), .rom_selected(rom_selected));
    crwm_host_model host (.clk(clk), .cpu_rdata(cpu_rdata),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .vid_bank(vid_bank), .vid_use_rom(vid_use_rom),
        .vid_req(vid_req), .vid_fetch(vid_fetch));
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Glyph zero as stored in the character ROM
    function automatic logic [7:0] rom_row(input logic [2:0] r);
        logic [63:0] g = 64'h3c666e6e60623c00;
        return g[63 - 8 * r -: 8];
    endfunction
    // Bank offset plus in-bank base plus glyph row
    function automatic logic [15:0] exp_addr(input int b, input int p,
                                             input int c, input int r);
        return 16'(b * BANK_BYTES + ((p / 2) * 2048 + c * 8 + r) % BANK_BYTES);
    endfunction
    // Load RAM for RAM fetches outside the window, fetch, then follow the pixels
    task automatic row_test(input logic [1:0] b, input logic rom,
                            input logic [7:0] c, input logic [2:0] r);
        logic [15:0] a;
        logic [3:0] fg;
        a = exp_addr(b, ptr, c, r);
        fg = 4'($random(seed));
        if (!rom && a[15:12] != SHARED_PAGE)
        begin
            host.wr(a, pat);
            host.rd(a, d);
            check("ram readback", d, pat);
        end
        host.wr(CHAR_POINTER_ADDR, {4'($random(seed)), ptr});
        host.fetch(b, rom, '{code: c, row: r, fg: fg});
        check("vid_addr", vid_addr, a);
        @(posedge clk);
        #1 check("vid_pattern", vid_pattern, pat);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            #1 check("pix_valid", pix_valid, 1'b1);
            check("pix_colour", pix_colour, pat[7-i] ? fg : bg);
        end
        @(posedge clk);
        #1 check("pix_valid end", pix_valid, 1'b0);
    endtask
    // Cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        host.rd(MEM_CONFIG_ADDR, d);
        check("config reset", d, MEM_CONFIG_RST);
        check("rom_selected reset", rom_selected, 1'b0);
        $display("test reset done");
        host.wr(MEM_CONFIG_ADDR, 8'h01);
        @(posedge clk);
        #1 check("rom_selected", rom_selected, 1'b1);
        for (int r = 0; r < 8; r++)
        begin
            host.rd(16'hd000 + 16'(r), d);
            check("rom byte", d, rom_row(3'(r)));
        end
        host.wr(16'hd000, 8'hff);
        host.rd(16'hd000, d);
        check("rom after write", d, 8'h3c);
        host.rd(CHAR_POINTER_ADDR, d);
        check("window hides pointer", d, 8'h00);
        host.wr(MEM_CONFIG_ADDR, 8'h00);
        host.rd(16'hd100, d);
        check("unmapped io", d, 8'h00);
        bg = 4'($random(seed));
        host.wr(BG_ZERO_ADDR, {4'h0, bg});
        host.rd(BG_ZERO_ADDR, d);
        check("bg zero", d, {4'h0, bg});
        $display("test window done");
        ptr = 4'h4;
        pat = 8'hff;
        row_test(2'd3, 1'b0, 8'h00, 3'd0);
        ptr = 4'h8;
        for (int r = 0; r < 8; r++)
        begin
            pat = rom_row(3'(r));
            row_test(2'(r), 1'b1, 8'h00, 3'(r));
        end
        for (int k = 0; k < 12; k++)
        begin
            ptr = (k % 3 == 0) ? 4'h8 : (k % 3 == 1) ? 4'hc : 4'he;
            ptr[0] = 1'($random(seed));
            pat = 8'($random(seed));
            row_test(2'(k / 3), 1'b0, 8'($random(seed)) & 8'h7f,
                     3'($random(seed)));
        end
        $display("test fetch done");
        complete_run();
    end
endmodule // crwm_top_test
bind crwm_top crwm_top_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .vid_bank(vid_bank),
    .vid_use_rom(vid_use_rom), .vid_req(vid_req), .vid_fetch(vid_fetch),
    .vid_addr(vid_addr), .vid_pattern(vid_pattern),
    .pix_valid(pix_valid), .pix_colour(pix_colour),
    .rom_selected(rom_selected));
`default_nettype wire
